/* hdl/sbrg_pkg.sv */
// Package for the serial rate generator: register map, field positions,
// reset values and divide factors.
// Assumes a single 50 MHz system clock and an 8-bit register port.
`default_nettype none

package sbrg_pkg;

    // ------------------------------------------------------------------
    // Register offsets (index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
    localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
    localparam logic [2:0] ADDR_RATE_CTRL = 3'h2;
    localparam logic [2:0] ADDR_DIV_HIGH = 3'h3;
    localparam logic [2:0] ADDR_DIV_LOW = 3'h4;
    localparam logic [2:0] ADDR_RATE_STATUS = 3'h5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_HIGH_SPEED_BIT = 2;
    localparam int TX_SHIFT_EMPTY_BIT = 1;
    localparam int RX_PORT_ENABLE_BIT = 7;
    localparam int RATE_IDLE_BIT = 6;
    localparam int RATE_WIDE_BIT = 3;
    localparam int STAT_RX_LEVEL_BIT = 0;
    localparam int STAT_TICK_SEEN_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] TX_CTRL_RESET = 8'h02;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
    localparam logic [7:0] RX_CTRL_RESET = 8'h00;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hF9;
    localparam logic [7:0] RATE_CTRL_RESET = 8'h40;
    localparam logic [7:0] RATE_CTRL_WMASK = 8'h9B;
    localparam logic [7:0] DIV_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Prescale factors applied in front of the divisor counter
    // ------------------------------------------------------------------
    localparam logic [5:0] PRE_DIV_64 = 6'h3F;
    localparam logic [5:0] PRE_DIV_16 = 6'h0F;
    localparam logic [5:0] PRE_DIV_4 = 6'h03;

    // Three samples per bit, spread over the prescale period
    localparam int SAMPLE_COUNT = 3;

endpackage : sbrg_pkg

`default_nettype wire

/* hdl/sbrg_rate_generator.sv */
// Serial rate generator with divisor registers and a three-sample
// majority detector on the receive line.
// Assumes rx input synchronous to clk_sys; one register access per cycle.
`default_nettype none

module sbrg_rate_generator (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // Serial line
    input wire logic rxPin,
    // Timing outputs
    output logic rateTick,
    output logic bitTick,
    output logic rxLevel
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic majority3(input logic [2:0] s);
        majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority3

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] txCtrl_q;
    logic [7:0] rxCtrl_q;
    logic [7:0] rateCtrl_q;
    logic [7:0] divHigh_q;
    logic [7:0] divLow_q;
    logic [15:0] divCnt_q;
    logic [15:0] divCnt_d;
    logic [5:0] preCnt_q;
    logic [5:0] preCnt_d;
    logic [2:0] samples_q;
    logic rxLevel_q;
    logic tickSeen_q;
    logic [7:0] rdData_q;
    logic rateTick_q;
    logic bitTick_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic wrTx = regWrStb && (regAddr == sbrg_pkg::ADDR_TX_CTRL);
    wire logic wrRx = regWrStb && (regAddr == sbrg_pkg::ADDR_RX_CTRL);
    wire logic wrRate = regWrStb && (regAddr == sbrg_pkg::ADDR_RATE_CTRL);
    wire logic wrHigh = regWrStb && (regAddr == sbrg_pkg::ADDR_DIV_HIGH);
    wire logic wrLow = regWrStb && (regAddr == sbrg_pkg::ADDR_DIV_LOW);
    wire logic rdStat = regRdStb && (regAddr == sbrg_pkg::ADDR_RATE_STATUS);
    wire logic portEnable = rxCtrl_q[sbrg_pkg::RX_PORT_ENABLE_BIT];
    wire logic syncMode = txCtrl_q[sbrg_pkg::TX_SYNC_BIT];
    wire logic highSpeed = txCtrl_q[sbrg_pkg::TX_HIGH_SPEED_BIT];
    wire logic wideSel = rateCtrl_q[sbrg_pkg::RATE_WIDE_BIT];
    wire logic divWrite = wrHigh || wrLow;

    wire logic [15:0] divisor = wideSel ? {divHigh_q, divLow_q} : {8'h00, divLow_q};

    // Prescale selects the 64, 16 or 4 factor ahead of the n+1 counter
    logic [5:0] preLimit;
    always_comb
    begin
        if (syncMode)
            preLimit = sbrg_pkg::PRE_DIV_4;
        else if (wideSel && highSpeed)
            preLimit = sbrg_pkg::PRE_DIV_4;
        else if (wideSel || highSpeed)
            preLimit = sbrg_pkg::PRE_DIV_16;
        else
            preLimit = sbrg_pkg::PRE_DIV_64;
    end

    wire logic preWrap = (preCnt_q >= preLimit);
    wire logic divWrap = preWrap && (divCnt_q >= divisor);
    // Sample points at one third steps across the prescale period
    wire logic [5:0] third = 6'((7'(preLimit) + 7'h01) / 7'h03);
    wire logic samplePt = portEnable && !divWrite &&
        ((preCnt_q == third) || (preCnt_q == 6'(third + third)) || preWrap);

    always_comb
    begin
        preCnt_d = preWrap ? 6'h00 : 6'(preCnt_q + 6'h01);
        divCnt_d = divCnt_q;
        if (preWrap)
            divCnt_d = divWrap ? 16'h0000 : 16'(divCnt_q + 16'h0001);
        // Disabled port holds the generator cleared
        if (divWrite || !portEnable)
        begin
            preCnt_d = 6'h00;
            divCnt_d = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            txCtrl_q <= sbrg_pkg::TX_CTRL_RESET;
            rxCtrl_q <= sbrg_pkg::RX_CTRL_RESET;
            rateCtrl_q <= sbrg_pkg::RATE_CTRL_RESET;
            divHigh_q <= sbrg_pkg::DIV_RESET;
            divLow_q <= sbrg_pkg::DIV_RESET;
        end
        else
        begin
            if (wrTx)
                txCtrl_q <= (regWrData & sbrg_pkg::TX_CTRL_WMASK) |
                    (txCtrl_q & ~sbrg_pkg::TX_CTRL_WMASK);
            if (wrRx)
                rxCtrl_q <= (regWrData & sbrg_pkg::RX_CTRL_WMASK) |
                    (rxCtrl_q & ~sbrg_pkg::RX_CTRL_WMASK);
            if (wrRate)
                rateCtrl_q <= (regWrData & sbrg_pkg::RATE_CTRL_WMASK) |
                    (rateCtrl_q & ~sbrg_pkg::RATE_CTRL_WMASK);
            if (wrHigh)
                divHigh_q <= regWrData;
            if (wrLow)
                divLow_q <= regWrData;
        end
    end

    // ------------------------------------------------------------------
    // Timer and sampling
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            preCnt_q <= 6'h00;
            divCnt_q <= 16'h0000;
            rateTick_q <= 1'b0;
            bitTick_q <= 1'b0;
        end
        else
        begin
            preCnt_q <= preCnt_d;
            divCnt_q <= divCnt_d;
            rateTick_q <= portEnable && !divWrite && preWrap;
            bitTick_q <= portEnable && !divWrite && divWrap;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            samples_q <= 3'h7;
            rxLevel_q <= 1'b1;
        end
        else
        begin
            if (samplePt)
                samples_q <= {samples_q[1:0], rxPin};
            if (bitTick_q)
                rxLevel_q <= majority3(samples_q);
        end
    end

    // Tick flag: hardware set wins over the clear-on-read
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            tickSeen_q <= 1'b0;
        else if (bitTick_q)
            tickSeen_q <= 1'b1;
        else if (rdStat)
            tickSeen_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic [7:0] rdMux;
    always_comb
    begin
        rdMux = 8'h00;
        unique case (regAddr)
            sbrg_pkg::ADDR_TX_CTRL: rdMux = txCtrl_q;
            sbrg_pkg::ADDR_RX_CTRL: rdMux = rxCtrl_q;
            sbrg_pkg::ADDR_RATE_CTRL: rdMux = rateCtrl_q;
            sbrg_pkg::ADDR_DIV_HIGH: rdMux = divHigh_q;
            sbrg_pkg::ADDR_DIV_LOW: rdMux = divLow_q;
            sbrg_pkg::ADDR_RATE_STATUS:
                rdMux = {6'h00, tickSeen_q, rxLevel_q};
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rdData_q <= 8'h00;
        else if (regRdStb)
            rdData_q <= rdMux;
        else
            rdData_q <= 8'h00;
    end

    assign regRdData = rdData_q;
    assign rateTick = rateTick_q;
    assign bitTick = bitTick_q;
    assign rxLevel = rxLevel_q;

endmodule : sbrg_rate_generator

`default_nettype wire

/* tb/sbrg_line_model.sv */
// Far-end line model: idle-high receive line with optional spikes.
// Assumes the bench changes lineLvl just after rising edges.
`default_nettype none

module sbrg_line_model (
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic lineLvl,
    input wire logic lineGlitch,
    // Line towards the block
    output logic rxPin
);
    logic [4:0] phaseQ = 5'h00;
    always_ff @(posedge clk_sys)
        phaseQ <= (phaseQ == 5'h1E) ? 5'h00 : 5'(phaseQ + 5'h01);
    // One spike per 31 cycles: a vote never holds two of them, and from one
    // 64-cycle bit to the next the spike slides across every sample point
    assign rxPin = lineLvl ^ (lineGlitch && phaseQ == 5'h00);
endmodule : sbrg_line_model

`default_nettype wire

/* tb/sbrg_rate_generator_props.sv */
// Checker: divide periods, timer clear, idle hold and the vote.
// Sees only top ports and mirrors the control bytes from writes.
`default_nettype none

module sbrg_rate_generator_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    // Line and timing
    input wire logic rxPin,
    input wire logic rateTick,
    input wire logic bitTick,
    input wire logic rxLevel
);
    // ----------
    // Mirror
    // ----------
    logic [7:0] regQ [0:4];
    logic seenQ;
    logic [23:0] cntQ;
    logic [6:0] stabQ;
    wire syncW = regQ[0][sbrg_pkg::TX_SYNC_BIT];
    wire fastW = regQ[0][sbrg_pkg::TX_HIGH_SPEED_BIT];
    wire wideW = regQ[2][sbrg_pkg::RATE_WIDE_BIT];
    wire [23:0] facW = (syncW || (wideW && fastW)) ? 24'h4 : (wideW || fastW) ? 24'h10 : 24'h40;
    wire [23:0] perW = facW * ({8'h00, wideW ? regQ[3] : 8'h00, regQ[4]} + 24'h1);
    wire divWrW = regWrStb && (regAddr == sbrg_pkg::ADDR_DIV_HIGH
        || regAddr == sbrg_pkg::ADDR_DIV_LOW);
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            regQ <= '{default: 8'h00};
            seenQ <= 1'b0;
            cntQ <= 24'h0;
            stabQ <= 7'h00;
        end
        else
        begin
            if (regWrStb && regAddr < 3'h5)
                regQ[regAddr] <= regWrData;
            // A write may change the period, so the next gap is not judged
            seenQ <= !regWrStb && (seenQ || bitTick);
            cntQ <= bitTick ? 24'h1 : cntQ + 24'h1;
            stabQ <= $changed(rxPin) ? 7'h00 : stabQ + {6'h00, ~&stabQ};
        end
    end
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    div_by_64_a: assert property (
        bitTick && seenQ && facW == 24'h40 |-> cntQ == perW) else $error("bad 64 period");
    div_by_16_a: assert property (
        bitTick && seenQ && facW == 24'h10 |-> cntQ == perW) else $error("bad 16 period");
    div_by_4_a: assert property (
        bitTick && seenQ && facW == 24'h4 |-> cntQ == perW) else $error("bad 4 period");
    write_clear_a: assert property (
        divWrW |=> (!bitTick && !rateTick) [*3]) else $error("tick soon after write");
    idle_hold_a: assert property (
        !regQ[1][sbrg_pkg::RX_PORT_ENABLE_BIT] |=> !bitTick && !rateTick)
        else $error("tick while off");
    rate_gap_a: assert property (
        rateTick |=> !rateTick [*3]) else $error("prescale ticks too close");
    vote_level_a: assert property (
        bitTick && stabQ > 7'h46 |-> ##2 rxLevel == $past(rxPin, 2)) else $error("bad vote");
    level_hold_a: assert property (
        $changed(rxLevel) |-> $past(bitTick)) else $error("level moved off tick");
endmodule : sbrg_rate_generator_props

bind sbrg_rate_generator sbrg_rate_generator_props sbrg_rate_generator_props_inst (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxPin(rxPin),
    .rateTick(rateTick), .bitTick(bitTick), .rxLevel(rxLevel));

`default_nettype wire

/* tb/sbrg_rate_generator_tb.sv */
// Bench: register access, divide periods, timer clear, idle hold, vote.
// Assumes one clock; all inputs change just after rising edges.
`default_nettype none

module sbrg_rate_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic lineLvl = 1'b1;
    logic lineGlitch = 1'b0;
    logic [7:0] regRdData;
    logic rxPin, rateTick, bitTick, rxLevel;
    int errors = 0;
    int checks = 0;
    int n;
    always #10 clk_sys = ~clk_sys;
    sbrg_rate_generator sbrg_rate_generator_inst (
        .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .rxPin(rxPin),
        .rateTick(rateTick), .bitTick(bitTick), .rxLevel(rxLevel));
    sbrg_line_model sbrg_line_model_inst (
        .clk_sys(clk_sys), .lineLvl(lineLvl), .lineGlitch(lineGlitch), .rxPin(rxPin));
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic cmpVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : cmpVal
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1;
        cmpVal($sformatf("register %0d", a), {24'h0, exp}, {24'h0, regRdData});
    endtask : rdChk
    task automatic waitTick(output int c);
        c = 0;
        // Outputs are read just after the edge, once they have settled
        do
        begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        while (bitTick !== 1'b1 && c < 9000);
    endtask : waitTick
    // Starts mid-count so a missing timer clear shows as an early tick
    task automatic rateCase(input logic [7:0] tx, rt, hi, lo, input int exp);
        int c1;
        int c2;
        repeat (20) @(posedge clk_sys);
        wr(sbrg_pkg::ADDR_TX_CTRL, tx);
        wr(sbrg_pkg::ADDR_RATE_CTRL, rt);
        wr(sbrg_pkg::ADDR_DIV_HIGH, hi);
        wr(sbrg_pkg::ADDR_DIV_LOW, lo);
        waitTick(c1);
        waitTick(c2);
        cmpVal("tick period", exp, c2);
        cmpVal("first tick", exp, c1);
    endtask : rateCase
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rdChk(3'(i), i == 0 ? sbrg_pkg::TX_CTRL_RESET
                : i == 1 ? sbrg_pkg::RX_CTRL_RESET
                : i == 2 ? sbrg_pkg::RATE_CTRL_RESET : sbrg_pkg::DIV_RESET);
        wr(sbrg_pkg::ADDR_DIV_HIGH, 8'hA5);
        wr(3'h7, 8'hFF);
        rdChk(sbrg_pkg::ADDR_DIV_HIGH, 8'hA5);
        rdChk(3'h7, 8'h00);
        // Read-only bits keep their values; port enable stays off here
        wr(sbrg_pkg::ADDR_TX_CTRL, 8'h00);
        rdChk(sbrg_pkg::ADDR_TX_CTRL, 8'h02);
        wr(sbrg_pkg::ADDR_RX_CTRL, 8'h7F);
        rdChk(sbrg_pkg::ADDR_RX_CTRL, 8'h79);
        wr(sbrg_pkg::ADDR_RATE_CTRL, 8'hFF);
        rdChk(sbrg_pkg::ADDR_RATE_CTRL, 8'hDB);
        n = 0;
        repeat (300)
        begin
            @(posedge clk_sys);
            #1;
            n += int'(bitTick === 1'b1 || rateTick === 1'b1);
        end
        cmpVal("ticks while off", 0, n);
        wr(sbrg_pkg::ADDR_RX_CTRL, 8'h80);
        rateCase(8'h00, 8'h00, 8'h05, 8'h02, 192);
        rateCase(8'h04, 8'h00, 8'h05, 8'h02, 48);
        rateCase(8'h00, 8'h08, 8'h01, 8'h02, 4144);
        rateCase(8'h14, 8'h00, 8'h05, 8'h03, 16);
        rateCase(8'h10, 8'h08, 8'h01, 8'h00, 1028);
        rateCase(8'h04, 8'h08, 8'h00, 8'h03, 16);
        rateCase(8'h00, 8'h00, 8'h07, 8'h00, 64);
        // Status: tick flag set by the last tick, cleared by the first read
        rdChk(sbrg_pkg::ADDR_RATE_STATUS, (8'h01 << sbrg_pkg::STAT_TICK_SEEN_BIT)
            | (8'h01 << sbrg_pkg::STAT_RX_LEVEL_BIT));
        rdChk(sbrg_pkg::ADDR_RATE_STATUS, 8'h01 << sbrg_pkg::STAT_RX_LEVEL_BIT);
        @(posedge clk_sys);
        lineLvl <= 1'b0;
        repeat (3) waitTick(n);
        cmpVal("rx level", 0, {31'h0, rxLevel});
        // Spikes drift over the sample points, so every settled bit is judged
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge clk_sys);
            lineGlitch <= 1'b1;
            lineLvl <= 1'(v);
            repeat (2) waitTick(n);
            repeat (31)
            begin
                waitTick(n);
                cmpVal("voted level", v, {31'h0, rxLevel});
            end
        end
        give_verdict();
    end
    initial
    begin
        #1000000;
        errors++;
        give_verdict();
    end
endmodule : sbrg_rate_generator_tb

`default_nettype wire
